/* logic/xbar_pkg.sv */
// Constants and types shared by the crossbar pin assignment logic.
// ****************************************************************
// What this block does
// RQ1: Analog pins need drive mode 0, latch 1 and skip bit 1.
// RQ2: A skipped pin is never claimed by the crossbar decoder.
// RQ3: Only unskipped pins P0.0 to P1.6 are crossbar candidates.
// RQ4: Enabled primary serial port takes P0.4 and P0.5, each pin unless it is skipped.
// RQ5: Enabled radio SPI port takes P1.0 to P1.3, each pin unless it is skipped.
// RQ6: Remaining peripherals, by priority, take lowest free unskipped pins.
// RQ7: The search passes over assigned or skipped pins to the next one.
// RQ8: With crossbar disabled all output drivers stay off.
// RQ9: Two-wire bus data and clock pins are forced open-drain.
// RQ10: General SPI slave select gets a pin only in four-wire mode.
// RQ11: General SPI wire mode shifts pins of all lower peripherals.
// RQ12: Software skips GPIO pins and pins of crossbar-bypassing functions.
// RQ13: Event capture sees edges on skipped and assigned digital pins.
// RQ14: Event capture never fires on analog-configured pins.
// RQ15: Oscillator input is P0.2, output P0.3, both bypass the crossbar.
// RQ16: Software writes port 0 skip mask 0x0C to reserve oscillator pins.
// RQ17: Analog pins disable receiver and pull-up and read back zero.
// RQ18: Skip bit n is pin n; assignment recomputes from current settings.
// ****************************************************************
package xbar_pkg;
	localparam int NUM_PINS = 15;
	localparam int NUM_FUNCS = 26;
	localparam int NUM_FIXED = 6;
	localparam int PIN_UART_BASE = 4;
	localparam int PIN_RADIO_BASE = 8;
	localparam int PIN_OSC_IN = 2;
	localparam int PIN_OSC_OUT = 3;
	localparam int FN_UART_TX = 0;
	localparam int FN_UART_RX = 1;
	localparam int FN_RADIO_BASE = 2;
	localparam int FN_GSPI_SCK = 6;
	localparam int FN_GSPI_MISO = 7;
	localparam int FN_GSPI_MOSI = 8;
	localparam int FN_GSPI_NSS = 9;
	localparam int FN_SMB_SDA = 10;
	localparam int FN_SMB_SCL = 11;
	localparam int FN_CP0 = 12;
	localparam int FN_CP0A = 13;
	localparam int FN_CP1 = 14;
	localparam int FN_CP1A = 15;
	localparam int FN_SYSCLK = 16;
	localparam int FN_CEX_BASE = 17;
	localparam int NUM_CEX = 6;
	localparam int FN_ECI = 23;
	localparam int FN_T0 = 24;
	localparam int FN_T1 = 25;
	localparam logic [1:0] NSS_THREE_WIRE = 2'h0;
	localparam logic [14:0] PAD_SYNC_RST = 15'h7fff;
	localparam logic [14:0] PAD_RST = 15'h0000;
	localparam logic [25:0] FUNC_RST = 26'h000_0000;
	localparam logic [4:0] PIN_FN_RST = 5'h00;

	typedef struct packed {
		logic uart_en;
		logic radio_en;
		logic gspi_en;
		logic smb_en;
		logic cp0_en;
		logic cp0a_en;
		logic cp1_en;
		logic cp1a_en;
		logic sysclk_en;
		logic [2:0] pca_cex;
		logic eci_en;
		logic t0_en;
		logic t1_en;
	} xbar_sel_s;

	typedef struct packed {
		logic valid;
		logic [3:0] pin;
	} func_map_s;
endpackage

/* logic/priority_crossbar_pin_assign.sv */
// Priority crossbar decoder, pad drive control and event capture.
`timescale 1ns/10ps
module priority_crossbar_pin_assign (
	// Clock and reset.
	input logic ref_clk,
	input logic rst,
	// Crossbar configuration.
	input xbar_pkg::xbar_sel_s sel,
	input logic crossbar_enable,
	input logic [1:0] slave_select_mode_field,
	input logic [7:0] port0_skip_mask,
	input logic [6:0] port1_skip_mask,
	// Pin cell configuration.
	input logic [14:0] output_drive_mode,
	input logic [14:0] analog_digital_select,
	input logic [14:0] port_latch,
	// Peripheral side.
	input logic [25:0] func_out,
	input logic [25:0] func_drive,
	output logic [25:0] func_in,
	output xbar_pkg::func_map_s [25:0] func_map,
	// Pads.
	input logic [14:0] pad_in,
	output logic [14:0] pad_out,
	output logic [14:0] pad_oe,
	output logic [14:0] weak_pullup_en,
	output logic [14:0] port_read,
	// Event capture.
	input logic [7:0] ext_int_pin_config,
	input logic [14:0] port_match_mask,
	input logic [14:0] port_match_value,
	output logic [1:0] ext_int_event,
	output logic port_match_event,
	output logic wake_event
);
	// ****************************************************************
	// Pin assignment and pad drive
	// ****************************************************************
	xbar_pkg::func_map_s [25:0] map_d;
	xbar_pkg::func_map_s [25:0] map_q;
	logic [14:0] pad_out_d;
	logic [14:0] pad_out_q;
	logic [14:0] pad_oe_d;
	logic [14:0] pad_oe_q;
	logic [14:0] pull_d;
	logic [14:0] pull_q;
	logic [25:0] func_in_d;
	logic [25:0] func_in_q;
	logic [14:0] stable_q;

	always_comb begin
		logic [14:0] skip;
		logic [14:0] used;
		logic [25:0] req;
		logic [4:0] pin_fn [15];
		logic four_wire;
		logic found;
		logic [3:0] fp;
		logic v;
		logic drv;
		logic od;
		skip = {port1_skip_mask, port0_skip_mask}; // [RQ18]
		used = '0;
		req = '0;
		found = 1'b0;
		fp = 4'h0;
		v = 1'b0;
		drv = 1'b0;
		od = 1'b0;
		for (int p = 0; p < xbar_pkg::NUM_PINS; p++) begin
			pin_fn[p] = xbar_pkg::PIN_FN_RST;
		end
		map_d = '0;
		four_wire = slave_select_mode_field != xbar_pkg::NSS_THREE_WIRE;
		req[xbar_pkg::FN_UART_TX] = sel.uart_en;
		req[xbar_pkg::FN_UART_RX] = sel.uart_en;
		for (int k = 0; k < 4; k++) begin
			req[xbar_pkg::FN_RADIO_BASE + k] = sel.radio_en;
		end
		req[xbar_pkg::FN_GSPI_SCK] = sel.gspi_en;
		req[xbar_pkg::FN_GSPI_MISO] = sel.gspi_en;
		req[xbar_pkg::FN_GSPI_MOSI] = sel.gspi_en;
		req[xbar_pkg::FN_GSPI_NSS] = sel.gspi_en && four_wire; // [RQ10]
		req[xbar_pkg::FN_SMB_SDA] = sel.smb_en;
		req[xbar_pkg::FN_SMB_SCL] = sel.smb_en;
		req[xbar_pkg::FN_CP0] = sel.cp0_en;
		req[xbar_pkg::FN_CP0A] = sel.cp0a_en;
		req[xbar_pkg::FN_CP1] = sel.cp1_en;
		req[xbar_pkg::FN_CP1A] = sel.cp1a_en;
		req[xbar_pkg::FN_SYSCLK] = sel.sysclk_en;
		for (int k = 0; k < xbar_pkg::NUM_CEX; k++) begin
			req[xbar_pkg::FN_CEX_BASE + k] = sel.pca_cex > 3'(k);
		end
		req[xbar_pkg::FN_ECI] = sel.eci_en;
		req[xbar_pkg::FN_T0] = sel.t0_en;
		req[xbar_pkg::FN_T1] = sel.t1_en;
		// Walking in priority order lets the SPI wire mode shift
		// everything below it without any special case.
		for (int f = 0; f < xbar_pkg::NUM_FUNCS; f++) begin // [RQ11]
			if (req[f] && f < xbar_pkg::NUM_FIXED) begin
				if (f < xbar_pkg::FN_RADIO_BASE) begin
					fp = 4'(xbar_pkg::PIN_UART_BASE + f); // [RQ4]
				end else begin
					fp = 4'(xbar_pkg::PIN_RADIO_BASE + f -
						xbar_pkg::FN_RADIO_BASE); // [RQ5]
				end
				// A skipped fixed pin stays unclaimed.
				if (!skip[fp]) begin // [RQ2]
					used[fp] = 1'b1;
					pin_fn[fp] = 5'(f);
					map_d[f].valid = 1'b1;
					map_d[f].pin = fp;
				end
			end else if (req[f]) begin
				found = 1'b0;
				// Only the fifteen crossbar pins are searched.
				for (int p = 0; p < xbar_pkg::NUM_PINS; p++) begin // [RQ3]
					if (!found && !skip[p] && !used[p]) begin // [RQ6] [RQ7]
						found = 1'b1;
						used[p] = 1'b1;
						pin_fn[p] = 5'(f);
						map_d[f].valid = 1'b1;
						map_d[f].pin = 4'(p);
					end
				end
			end
		end
		// Oscillator pins get no special path; software skips them.
		for (int i = 0; i < xbar_pkg::NUM_PINS; i++) begin // [RQ15]
			v = port_latch[i];
			drv = 1'b1;
			od = 1'b0;
			if (used[i]) begin
				v = func_out[pin_fn[i]];
				drv = func_drive[pin_fn[i]];
				od = pin_fn[i] == 5'(xbar_pkg::FN_SMB_SDA) ||
					pin_fn[i] == 5'(xbar_pkg::FN_SMB_SCL); // [RQ9]
			end
			pad_out_d[i] = v;
			pad_oe_d[i] = crossbar_enable && drv &&
				((output_drive_mode[i] && !od) || !v); // [RQ8] [RQ9]
			pull_d[i] = analog_digital_select[i] &&
				!(pad_oe_d[i] && !v); // [RQ17]
		end
		for (int f = 0; f < xbar_pkg::NUM_FUNCS; f++) begin
			func_in_d[f] = map_d[f].valid &&
				stable_q[map_d[f].pin] &&
				analog_digital_select[map_d[f].pin];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			map_q <= '0;
			pad_out_q <= xbar_pkg::PAD_RST;
			pad_oe_q <= xbar_pkg::PAD_RST;
			pull_q <= xbar_pkg::PAD_RST;
			func_in_q <= xbar_pkg::FUNC_RST;
		end else begin
			map_q <= map_d;
			pad_out_q <= pad_out_d;
			pad_oe_q <= pad_oe_d;
			pull_q <= pull_d;
			func_in_q <= func_in_d;
		end
	end

	assign func_map = map_q;
	assign pad_out = pad_out_q;
	assign pad_oe = pad_oe_q;
	assign weak_pullup_en = pull_q;
	assign func_in = func_in_q;

	// ****************************************************************
	// Pad synchronisers and event capture
	// ****************************************************************
	logic [14:0] s1_q;
	logic [14:0] s2_q;
	logic [14:0] s3_q;
	logic [14:0] stable_d;
	logic [14:0] read_d;
	logic [14:0] read_q;
	logic [1:0] ext_d;
	logic [1:0] ext_q;
	logic mis_d;
	logic mis_q;
	logic match_d;
	logic match_q;
	logic wake_d;
	logic wake_q;

	// A change is accepted only once two later stages agree, which
	// costs latency but rejects a single metastable sample.
	always_comb begin
		logic [14:0] agree;
		logic [14:0] edge_v;
		logic [2:0] p0;
		logic [2:0] p1;
		agree = ~(s2_q ^ s3_q);
		edge_v = '0;
		p0 = ext_int_pin_config[2:0];
		p1 = ext_int_pin_config[6:4];
		stable_d = (agree & s3_q) | (~agree & stable_q);
		edge_v = (stable_d ^ stable_q) & analog_digital_select; // [RQ14]
		read_d = stable_d & analog_digital_select; // [RQ17]
		// Edges are seen whatever the skip bit of the pin is.
		ext_d[0] = edge_v[p0] &&
			stable_d[p0] == ext_int_pin_config[3]; // [RQ13]
		ext_d[1] = edge_v[p1] &&
			stable_d[p1] == ext_int_pin_config[7]; // [RQ13]
		mis_d = |((stable_d ^ port_match_value) & port_match_mask &
			analog_digital_select); // [RQ14]
		match_d = mis_d && !mis_q;
		wake_d = |ext_d || match_d;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s1_q <= xbar_pkg::PAD_SYNC_RST;
			s2_q <= xbar_pkg::PAD_SYNC_RST;
			s3_q <= xbar_pkg::PAD_SYNC_RST;
			stable_q <= xbar_pkg::PAD_SYNC_RST;
			read_q <= xbar_pkg::PAD_RST;
			ext_q <= 2'h0;
			mis_q <= 1'b0;
			match_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			s1_q <= pad_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			stable_q <= stable_d;
			read_q <= read_d;
			ext_q <= ext_d;
			mis_q <= mis_d;
			match_q <= match_d;
			wake_q <= wake_d;
		end
	end

	assign port_read = read_q;
	assign ext_int_event = ext_q;
	assign port_match_event = match_q;
	assign wake_event = wake_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	logic [14:0] claimed;

	always_comb begin
		claimed = '0;
		for (int f = 0; f < xbar_pkg::NUM_FUNCS; f++) begin
			if (map_q[f].valid) begin
				claimed[map_q[f].pin] = 1'b1;
			end
		end
	end

	chk_skip_never_used: assert property ( // [RQ2]
		@(posedge ref_clk) disable iff (rst)
		!$past(rst) |->
		(claimed & $past({port1_skip_mask, port0_skip_mask})) ==
		15'h0000)
		else $error("skipped pin claimed");

	chk_uart_fixed_pins: assert property ( // [RQ4]
		@(posedge ref_clk) disable iff (rst)
		!$past(rst) && $past(sel.uart_en && !port0_skip_mask[4] &&
		!port0_skip_mask[5]) |->
		map_q[xbar_pkg::FN_UART_TX].valid &&
		map_q[xbar_pkg::FN_UART_TX].pin == 4'h4 &&
		map_q[xbar_pkg::FN_UART_RX].valid &&
		map_q[xbar_pkg::FN_UART_RX].pin == 4'h5)
		else $error("serial port not on fixed pins");

	chk_radio_fixed_pins: assert property ( // [RQ5]
		@(posedge ref_clk) disable iff (rst)
		!$past(rst) && $past(sel.radio_en && !port1_skip_mask[0]) |->
		map_q[xbar_pkg::FN_RADIO_BASE].valid &&
		map_q[xbar_pkg::FN_RADIO_BASE].pin == 4'h8)
		else $error("radio port not on fixed pins");

	chk_xbar_off_drivers: assert property ( // [RQ8]
		@(posedge ref_clk) disable iff (rst)
		!$past(crossbar_enable) |-> pad_oe_q == 15'h0000)
		else $error("driver on with crossbar disabled");

	chk_bus_open_drain: assert property ( // [RQ9]
		@(posedge ref_clk) disable iff (rst)
		map_q[xbar_pkg::FN_SMB_SDA].valid &&
		pad_oe_q[map_q[xbar_pkg::FN_SMB_SDA].pin] |->
		!pad_out_q[map_q[xbar_pkg::FN_SMB_SDA].pin])
		else $error("bus data pin driven high");

	chk_nss_four_wire: assert property ( // [RQ10]
		@(posedge ref_clk) disable iff (rst)
		!$past(rst) && map_q[xbar_pkg::FN_GSPI_NSS].valid |->
		$past(slave_select_mode_field) != xbar_pkg::NSS_THREE_WIRE)
		else $error("slave select routed in three-wire mode");

	chk_event_digital: assert property ( // [RQ14]
		@(posedge ref_clk) disable iff (rst)
		ext_q[0] |->
		$past(analog_digital_select[ext_int_pin_config[2:0]]))
		else $error("event on analog pin");

	chk_analog_read_zero: assert property ( // [RQ17]
		@(posedge ref_clk) disable iff (rst)
		!$past(rst) |->
		(read_q & ~$past(analog_digital_select)) == 15'h0000)
		else $error("analog pin reads one");
endmodule

/* verif/priority_crossbar_pin_assign_bench.sv */
// Self-checking bench for the crossbar pin assignment block.
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
num_errors++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module priority_crossbar_pin_assign_bench;
	typedef struct packed {
		logic [2:0] kind;
		logic [3:0] idx;
		logic [129:0] val;
	} note_s;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	xbar_pkg::xbar_sel_s sel = '0;
	logic crossbar_enable = 1'b0;
	logic [1:0] slave_select_mode_field = 2'h0;
	logic [7:0] port0_skip_mask = 8'h00;
	logic [6:0] port1_skip_mask = 7'h00;
	logic [14:0] output_drive_mode = '0, analog_digital_select = '1;
	logic [14:0] pad_in = '1, pad_out, pad_oe, weak_pullup_en, port_read;
	logic [14:0] port_latch = '0, port_match_mask = '0;
	logic [14:0] port_match_value = '0;
	logic [25:0] func_out = '0, func_drive = '0, func_in;
	logic [7:0] ext_int_pin_config = 8'h00;
	logic [1:0] ext_int_event;
	logic [3:0] seen = 4'h0;
	logic seen_clr = 1'b0;
	logic port_match_event, wake_event;
	xbar_pkg::func_map_s [25:0] func_map;
	note_s notes[$];
	note_s n;
	event chk_ev;
	int num_errors = 0;
	int n_tests = 0;

	always #5 ref_clk = ~ref_clk;

	priority_crossbar_pin_assign DUT (.ref_clk(ref_clk), .rst(rst),
		.sel(sel), .crossbar_enable(crossbar_enable),
		.slave_select_mode_field(slave_select_mode_field),
		.port0_skip_mask(port0_skip_mask), .port1_skip_mask(port1_skip_mask),
		.output_drive_mode(output_drive_mode),
		.analog_digital_select(analog_digital_select),
		.port_latch(port_latch), .func_out(func_out),
		.func_drive(func_drive),
		.func_in(func_in), .func_map(func_map), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .weak_pullup_en(weak_pullup_en),
		.port_read(port_read), .ext_int_pin_config(ext_int_pin_config),
		.port_match_mask(port_match_mask),
		.port_match_value(port_match_value),
		.ext_int_event(ext_int_event), .port_match_event(port_match_event),
		.wake_event(wake_event));

	always @(posedge ref_clk) begin
		seen <= seen_clr ? 4'h0 :
			seen | {port_match_event, wake_event, ext_int_event};
	end

	// ****************************************
	// Reference assignment, built independently of the decoder.
	// ****************************************
	function automatic logic [129:0] model(xbar_pkg::xbar_sel_s s,
		logic [1:0] nss, logic [14:0] skip);
		xbar_pkg::func_map_s [25:0] m;
		logic [25:0] want;
		logic [14:0] used;
		int p;
		m = '0;
		used = '0;
		want = '0;
		p = 0;
		for (int i = 0; i < 2; i++) if (s.uart_en && !skip[4 + i]) begin
			m[i] = {1'b1, 4'(4 + i)};
			used[4 + i] = 1'b1;
		end
		for (int i = 0; i < 4; i++) if (s.radio_en && !skip[8 + i]) begin
			m[2 + i] = {1'b1, 4'(8 + i)};
			used[8 + i] = 1'b1;
		end
		want[9:6] = {s.gspi_en && nss != 2'h0, {3{s.gspi_en}}};
		want[16:10] = {s.sysclk_en, s.cp1a_en, s.cp1_en, s.cp0a_en, s.cp0_en,
			{2{s.smb_en}}};
		for (int k = 0; k < 6; k++) want[17 + k] = k < s.pca_cex;
		want[25:23] = {s.t1_en, s.t0_en, s.eci_en};
		for (int f = 6; f < 26; f++) if (want[f]) begin
			while (p < 15 && (skip[p] || used[p])) p++;
			if (p < 15) begin
				m[f] = {1'b1, 4'(p)};
				used[p] = 1'b1;
			end
		end
		return m;
	endfunction

	// Results are read at a falling edge, after the registered update lands.
	task automatic settle(input int cycles);
		repeat (cycles) @(negedge ref_clk);
		-> chk_ev;
		#1;
	endtask

	task automatic note(input logic [2:0] k, input int i, input logic v);
		notes.push_back('{k, 4'(i), 130'(v)});
	endtask

	task automatic map_case(input xbar_pkg::xbar_sel_s s, input logic [1:0] m,
		input logic [14:0] skip);
		@(negedge ref_clk);
		sel = s;
		slave_select_mode_field = m;
		{port1_skip_mask, port0_skip_mask} = skip;
		notes.push_back('{3'd0, 4'h0, model(s, m, skip)});
		settle(2);
	endtask

	// One pad: crossbar enable, two-wire bus or serial port, driven value.
	task automatic drive_case(input logic en, input logic smb,
		input logic v, input int pin, input logic exp);
		@(negedge ref_clk);
		sel = '0;
		sel.smb_en = smb;
		sel.uart_en = !smb;
		{port1_skip_mask, port0_skip_mask} = 15'h0000;
		output_drive_mode = '1;
		func_drive = '1;
		func_out = {26{v}};
		crossbar_enable = en;
		note(3'd1, pin, exp);
		note(3'd5, pin, v);
		settle(2);
	endtask

	always begin
		@(chk_ev);
		while (notes.size() > 0) begin
			n = notes.pop_front();
			case (n.kind)
				3'd0: `CHK(func_map, n.val)
				3'd1: `CHK(pad_oe[n.idx], n.val[0])
				3'd2: `CHK(port_read[n.idx], n.val[0])
				3'd3: `CHK(weak_pullup_en[n.idx], n.val[0])
				3'd4: `CHK(seen[n.idx], n.val[0])
				3'd5: `CHK(pad_out[n.idx], n.val[0])
				default: `CHK(func_in[n.idx], n.val[0])
			endcase
		end
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ****************************************
	// Test sequence.
	// ****************************************
	initial begin
		xbar_pkg::xbar_sel_s s;
		void'($urandom(95908));
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		s = '0;
		s.uart_en = 1'b1;
		map_case(s, 2'h0, 15'h0000);
		map_case(s, 2'h0, 15'h0010); // Fixed pin skipped: left unassigned.
		s = '1;
		s.pca_cex = 3'd6;
		for (int m = 0; m < 4; m++) map_case(s, 2'(m), 15'h0000);
		map_case(s, 2'h1, 15'h000c); // Oscillator pins reserved.
		$display("test fixed_and_modes done");
		for (int r = 0; r < 300; r++) begin
			s = xbar_pkg::xbar_sel_s'(15'($urandom));
			if (s.pca_cex > 3'd6) s.pca_cex = 3'($urandom_range(6));
			map_case(s, 2'($urandom), 15'($urandom) & 15'($urandom));
		end
		$display("test random_maps done");
		drive_case(1'b0, 1'b0, 1'b0, 4, 1'b0);
		drive_case(1'b1, 1'b0, 1'b1, 4, 1'b1);
		drive_case(1'b1, 1'b1, 1'b1, 0, 1'b0);
		drive_case(1'b1, 1'b1, 1'b1, 1, 1'b0);
		drive_case(1'b1, 1'b1, 1'b0, 0, 1'b1);
		drive_case(1'b0, 1'b1, 1'b0, 1, 1'b0);
		$display("test drivers done");
		@(negedge ref_clk);
		crossbar_enable = 1'b0;
		sel = '0;
		{port1_skip_mask, port0_skip_mask} = 15'h7fff;
		analog_digital_select = 15'h7ff7;
		output_drive_mode = 15'h7ff7;
		port_latch = 15'h0008;
		ext_int_pin_config = 8'hdb;
		port_match_mask = 15'h0020;
		pad_in = 15'h0000;
		settle(8);
		seen_clr = 1'b1;
		@(negedge ref_clk);
		seen_clr = 1'b0;
		pad_in = 15'h7fff;
		note(3'd4, 1, 1'b1);
		note(3'd4, 0, 1'b0);
		note(3'd4, 2, 1'b1);
		note(3'd4, 3, 1'b1);
		note(3'd2, 3, 1'b0);
		note(3'd2, 5, 1'b1);
		note(3'd3, 3, 1'b0);
		settle(8);
		$display("test events done");
		@(negedge ref_clk);
		sel.uart_en = 1'b1;
		{port1_skip_mask, port0_skip_mask} = 15'h7fcf;
		note(3'd6, 1, 1'b1);
		note(3'd6, 0, 1'b1);
		note(3'd6, 2, 1'b0);
		settle(2);
		$display("test func_in done");
		report_and_stop();
	end

	initial begin
		#200000;
		num_errors++;
		report_and_stop();
	end
endmodule
